// ===== rtl/adc_ctrl_pkg.sv
// Summary of operation
// - The block powers down whenever the sample clock is stopped or slower than 1 MHz.
// - Between 1 MHz and 10 MHz power-down may or may not happen; here a period threshold decides.
// - A power-down set in the mode register three-states the data, over-range and data-ready clock outputs.
// - After reset the loop is active; bypass only when programmed.
// - With the loop active or bypassed, a missing or slow clock forces power-down.
// - Each result leaves as a 14-bit word, msb on the top bit and lsb on the bottom bit.
// - The over-range flag is 1 when the code sits at either full-scale limit, else 0.
// - The four-level format strap picks binary or two's complement and the output clock edge.
// - Outputs are driven while output enable is high and three-stated while it is low.
// - A reset pulse of at least 2 us clears the mode register, the converter and the data outputs.
// - The host writes the mode register over a three-wire serial link.
// - Each conversion starts on the falling edge of the sample clock.
// - Each sample appears on the output 16.5 sample clock cycles after it was captured.
package adc_ctrl_pkg;
    localparam int DATA_W = 14;
    localparam int MODE_W = 16;
    localparam int IRQ_W = 4;
    localparam int CLK_PERIOD_NS = 100;
    // Slow-clock limit as a sample clock period
    localparam int PD_PERIOD_NS = 1000;
    localparam int PD_CYC = PD_PERIOD_NS / CLK_PERIOD_NS;
    // Least reset pulse, rounded up to whole cycles
    localparam int RST_MIN_NS = 2000;
    localparam int RST_MIN_CYC = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Latency in half sample clock cycles
    localparam int LAT_HALF_CYC = 33;
    localparam int LAT_BACK = LAT_HALF_CYC / 2 + 1;
    localparam int MEM_DEPTH = 32;
    localparam int MEM_AW = 5;
    localparam int PD_BIT_DEF = 0;
    localparam int DLL_OFF_BIT_DEF = 1;
    localparam logic [MODE_W-1:0] MODE_RST = 16'h0000;
    localparam logic [DATA_W-1:0] CODE_MAX = 14'h3fff;
    localparam logic [DATA_W-1:0] CODE_MIN = 14'h0000;
    // Register byte addresses
    localparam logic [7:0] ADDR_MODE = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
    localparam logic [7:0] ADDR_SAMPLE = 8'h10;
    // Interrupt bits
    localparam int IRQ_PD_ENTER = 0;
    localparam int IRQ_PD_EXIT = 1;
    localparam int IRQ_OVR = 2;
    localparam int IRQ_SER_WR = 3;
    // Strap fields
    localparam int STRAP_TWOS = 0;
    localparam int STRAP_FALL = 1;
    typedef enum logic [1:0] {ST_RESET, ST_RUN, ST_CLK_PD, ST_PROG_PD} pwr_state_t;
endpackage : adc_ctrl_pkg

// ===== rtl/sample_mem.sv
`timescale 1ns/1ns
// Pipeline delay store with registered read port
module sample_mem
    import adc_ctrl_pkg::*;
#(
    parameter int WIDTH = DATA_W,
    parameter int DEPTH = MEM_DEPTH,
    parameter int AW = MEM_AW
)
(
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_wr_en,
    input wire logic [AW-1:0] i_wr_addr,
    input wire logic [WIDTH-1:0] i_wr_data,
    input wire logic i_rd_en,
    input wire logic [AW-1:0] i_rd_addr,
    output logic [WIDTH-1:0] o_rd_data
);
    logic [WIDTH-1:0] mem_q [DEPTH];

    // Array kept without reset so it maps onto plain storage
    always_ff @(posedge i_clk_sys)
    begin
        if (i_wr_en)
        begin
            mem_q[i_wr_addr] <= i_wr_data;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_rd_data <= '0;
        end
        else if (i_rd_en)
        begin
            o_rd_data <= mem_q[i_rd_addr];
        end
    end
endmodule : sample_mem

// ===== rtl/adc_ctrl.sv
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ns
module adc_ctrl
    import adc_ctrl_pkg::*;
#(
    parameter int PD_BIT = PD_BIT_DEF,
    parameter int DLL_OFF_BIT = DLL_OFF_BIT_DEF
)
(
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_sample_clk,
    input wire logic [DATA_W-1:0] i_conv_code,
    input wire logic i_output_enable,
    input wire logic i_reset_pin,
    input wire logic [1:0] i_format_polarity_strap,
    input wire logic i_ser_clk,
    input wire logic i_ser_sel_n,
    input wire logic i_ser_data,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic [DATA_W-1:0] o_data,
    output logic o_data_oe,
    output logic o_over_range_flag,
    output logic o_ovr_oe,
    output logic o_data_ready_clock,
    output logic o_clk_oe,
    output logic o_power_down,
    output logic o_dll_bypass,
    output logic o_irq
);
    localparam int NSYNC = DATA_W + 8; // Code word rides in the top bits
    logic rst_s1_q, rst_n_q;
    logic [NSYNC-1:0] sync1_q, sync2_q;
    logic sclk_prev_q, serclk_prev_q, sersel_prev_q;
    logic [$clog2(PD_CYC+2)-1:0] per_cnt_q;
    logic [$clog2(RST_MIN_CYC+1)-1:0] rst_cnt_q;
    logic soft_rst_q;
    pwr_state_t state_q, state_d;
    logic [MODE_W-1:0] mode_q, ser_sr_q;
    logic [$clog2(MODE_W+1)-1:0] ser_cnt_q;
    logic [1:0] strap_q;
    logic [MEM_AW-1:0] wptr_q;
    logic [MEM_AW:0] fill_q;
    logic rd_valid_q, ovr_q;
    logic [DATA_W-1:0] rd_data, data_q;
    logic [2:0] sclk_dly_q;
    logic drdy_q;
    logic [IRQ_W-1:0] irq_stat_q, irq_mask_q, irq_ev;
    logic [31:0] prdata_q;

    // Release reset through two flops
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    // Every pin input passes two flops; only the second is read
    always_ff @(posedge i_clk_sys or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
        end
        else
        begin
            sync1_q <= {i_conv_code, i_format_polarity_strap, i_ser_data, i_ser_sel_n,
                        i_ser_clk, i_reset_pin, i_output_enable, i_sample_clk};
            sync2_q <= sync1_q;
        end
    end

    wire sclk_s = sync2_q[0];
    wire oe_s = sync2_q[1];
    wire rpin_s = sync2_q[2];
    wire serclk_s = sync2_q[3];
    wire sersel_n_s = sync2_q[4];
    wire serdat_s = sync2_q[5];
    // Code synced with the sample clock so both arrive with the same lag
    wire [DATA_W-1:0] code_s = sync2_q[NSYNC-1:8];
    wire sclk_fall = sclk_prev_q & ~sclk_s;
    wire sclk_rise = ~sclk_prev_q & sclk_s;
    wire ser_rise = ~serclk_prev_q & serclk_s;
    wire ser_end = ~sersel_prev_q & sersel_n_s;
    wire slow_clk = per_cnt_q > ($bits(per_cnt_q))'(PD_CYC);
    wire pd_bit = mode_q[PD_BIT];
    wire ser_wr = ser_end & (ser_cnt_q == ($bits(ser_cnt_q))'(MODE_W));

    // Edge history and slow-clock period counter
    always_ff @(posedge i_clk_sys or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            sclk_prev_q <= 1'b0;
            serclk_prev_q <= 1'b0;
            sersel_prev_q <= 1'b1;
            per_cnt_q <= ($bits(per_cnt_q))'(PD_CYC + 1);
            sclk_dly_q <= '0;
        end
        else
        begin
            sclk_prev_q <= sclk_s;
            serclk_prev_q <= serclk_s;
            sersel_prev_q <= sersel_n_s;
            sclk_dly_q <= {sclk_dly_q[1:0], sclk_s};
            if (sclk_fall)
                per_cnt_q <= '0;
            else if (!slow_clk)
                per_cnt_q <= per_cnt_q + 1'b1; // saturates one past the limit
        end
    end

    // Reset pin must stay high for the full width; shorter glitches are ignored
    always_ff @(posedge i_clk_sys or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            rst_cnt_q <= '0;
            soft_rst_q <= 1'b0;
            strap_q <= '0;
        end
        else
        begin
            strap_q <= sync2_q[7:6];
            if (!rpin_s)
            begin
                rst_cnt_q <= '0;
                soft_rst_q <= 1'b0;
            end
            else if (rst_cnt_q == ($bits(rst_cnt_q))'(RST_MIN_CYC - 1))
                soft_rst_q <= 1'b1;
            else
                rst_cnt_q <= rst_cnt_q + 1'b1;
        end
    end

    // Power state selection, reset pin first, then programmed power-down
    always_comb
    begin
        case (state_q)
            ST_RESET, ST_RUN, ST_CLK_PD, ST_PROG_PD:
            begin
                if (soft_rst_q)
                    state_d = ST_RESET;
                else if (pd_bit)
                    state_d = ST_PROG_PD;
                else if (slow_clk)
                    state_d = ST_CLK_PD;
                else
                    state_d = ST_RUN;
            end
            default: state_d = ST_RESET;
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge rst_n_q)
    begin
        if (!rst_n_q)
            state_q <= ST_RESET;
        else
            state_q <= state_d;
    end

    // Three-wire receiver: shift on clock rise, commit on select release
    always_ff @(posedge i_clk_sys or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            ser_sr_q <= '0;
            ser_cnt_q <= '0;
        end
        else if (sersel_n_s)
            ser_cnt_q <= ser_end ? ser_cnt_q : '0;
        else if (ser_rise)
        begin
            ser_sr_q <= {ser_sr_q[MODE_W-2:0], serdat_s};
            if (ser_cnt_q != ($bits(ser_cnt_q))'(MODE_W))
                ser_cnt_q <= ser_cnt_q + 1'b1;
        end
    end

    wire apb_wr = i_psel & i_penable & i_pwrite;
    wire apb_rd_setup = i_psel & ~i_penable & ~i_pwrite;
    wire addr_ok = (i_paddr == ADDR_MODE) | (i_paddr == ADDR_STATUS) |
                   (i_paddr == ADDR_IRQ_STAT) | (i_paddr == ADDR_IRQ_MASK) |
                   (i_paddr == ADDR_SAMPLE);
    wire wr_mode = apb_wr & (i_paddr == ADDR_MODE);
    wire wr_clr = apb_wr & (i_paddr == ADDR_IRQ_STAT);
    wire wr_mask = apb_wr & (i_paddr == ADDR_IRQ_MASK);
    wire [7:0] status = {2'b00, strap_q, o_dll_bypass, 1'(state_q == ST_RUN),
                         1'(state_q == ST_CLK_PD), 1'(state_q == ST_PROG_PD)};

    // Mode register: serial frame wins over a bus write in the same cycle
    always_ff @(posedge i_clk_sys or negedge rst_n_q)
    begin
        if (!rst_n_q)
            mode_q <= MODE_RST;
        else if (soft_rst_q)
            mode_q <= MODE_RST;
        else if (ser_wr)
            mode_q <= ser_sr_q;
        else if (wr_mode)
            mode_q <= i_pwdata[MODE_W-1:0];
    end

    // Interrupt events; a new event beats a clear in the same cycle
    assign irq_ev[IRQ_PD_ENTER] = (state_d == ST_CLK_PD || state_d == ST_PROG_PD) &&
                                  (state_q == ST_RUN);
    assign irq_ev[IRQ_PD_EXIT] = (state_d == ST_RUN) && (state_q != ST_RUN);
    assign irq_ev[IRQ_OVR] = rd_valid_q && (rd_data == CODE_MAX || rd_data == CODE_MIN);
    assign irq_ev[IRQ_SER_WR] = ser_wr;

    always_ff @(posedge i_clk_sys or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            irq_stat_q <= '0;
            irq_mask_q <= '0;
            prdata_q <= '0;
        end
        else
        begin
            irq_stat_q <= (irq_stat_q & ~(wr_clr ? i_pwdata[IRQ_W-1:0] : '0)) | irq_ev;
            if (wr_mask)
                irq_mask_q <= i_pwdata[IRQ_W-1:0];
            if (apb_rd_setup)
                prdata_q <= (i_paddr == ADDR_MODE) ? 32'(mode_q) :
                            (i_paddr == ADDR_STATUS) ? 32'(status) :
                            (i_paddr == ADDR_IRQ_STAT) ? 32'(irq_stat_q) :
                            (i_paddr == ADDR_IRQ_MASK) ? 32'(irq_mask_q) :
                            (i_paddr == ADDR_SAMPLE) ? 32'(data_q) : 32'h0000_0000;
        end
    end

    // Zero-wait slave; read data was prepared in the setup cycle
    assign o_prdata = prdata_q;
    assign o_pready = 1'b1;
    assign o_pslverr = i_psel & i_penable & ~addr_ok;
    assign o_irq = |(irq_stat_q & irq_mask_q);

    // Capture on the falling sample clock edge, read back the one 16.5 cycles old
    wire run = (state_q == ST_RUN);
    wire cap_en = run & sclk_fall;
    wire rd_en = run & sclk_rise & (fill_q >= ($bits(fill_q))'(LAT_BACK));
    wire [MEM_AW-1:0] rd_addr = wptr_q - MEM_AW'(LAT_BACK);

    sample_mem u_mem (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(rst_n_q),
        .i_wr_en(cap_en),
        .i_wr_addr(wptr_q),
        .i_wr_data(code_s),
        .i_rd_en(rd_en),
        .i_rd_addr(rd_addr),
        .o_rd_data(rd_data)
    );

    // Pipeline pointers restart on reset or any power-down
    always_ff @(posedge i_clk_sys or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            wptr_q <= '0;
            fill_q <= '0;
            rd_valid_q <= 1'b0;
        end
        else
        begin
            rd_valid_q <= rd_en;
            if (!run)
            begin
                wptr_q <= '0;
                fill_q <= '0;
            end
            else if (cap_en)
            begin
                wptr_q <= wptr_q + 1'b1;
                if (fill_q < ($bits(fill_q))'(LAT_BACK))
                    fill_q <= fill_q + 1'b1;
            end
        end
    end

    // Output word and flags; two's complement flips only the msb
    always_ff @(posedge i_clk_sys or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            data_q <= '0;
            ovr_q <= 1'b0;
            drdy_q <= 1'b0;
        end
        else
        begin
            drdy_q <= sclk_dly_q[2] ^ strap_q[STRAP_FALL];
            if (soft_rst_q)
            begin
                data_q <= '0;
                ovr_q <= 1'b0;
            end
            else if (rd_valid_q)
            begin
                data_q <= {rd_data[DATA_W-1] ^ strap_q[STRAP_TWOS],
                           rd_data[DATA_W-2:0]};
                ovr_q <= irq_ev[IRQ_OVR];
            end
        end
    end

    // Pins float when disabled or powered down by the mode bit
    wire drive = oe_s & (state_q != ST_PROG_PD);
    assign o_data = data_q;
    assign o_over_range_flag = ovr_q;
    assign o_data_ready_clock = drdy_q;
    assign o_data_oe = drive;
    assign o_ovr_oe = drive;
    assign o_clk_oe = drive;
    assign o_power_down = (state_q == ST_CLK_PD) | (state_q == ST_PROG_PD);
    assign o_dll_bypass = mode_q[DLL_OFF_BIT];

    property p_slow_pd;
        @(posedge i_clk_sys) disable iff (!rst_n_q)
        slow_clk && !soft_rst_q && !pd_bit |=> state_q == ST_CLK_PD;
    endproperty
    a_slow_pd: assert property (p_slow_pd) else $error("slow clock without power-down");

    property p_run_fast;
        @(posedge i_clk_sys) disable iff (!rst_n_q)
        slow_clk |=> state_q != ST_RUN;
    endproperty
    a_run_fast: assert property (p_run_fast) else $error("running on slow clock");

    property p_prog_pd_float;
        @(posedge i_clk_sys) disable iff (!rst_n_q)
        pd_bit && !soft_rst_q |=> !o_data_oe && !o_ovr_oe && !o_clk_oe;
    endproperty
    a_prog_pd_float: assert property (p_prog_pd_float) else $error("outputs driven in pd");

    property p_dll_default;
        @(posedge i_clk_sys) disable iff (!rst_n_q)
        soft_rst_q |=> !o_dll_bypass;
    endproperty
    a_dll_default: assert property (p_dll_default) else $error("bypass set after reset");

    property p_no_cap_pd;
        @(posedge i_clk_sys) disable iff (!rst_n_q)
        o_power_down |-> !cap_en && !rd_en;
    endproperty
    a_no_cap_pd: assert property (p_no_cap_pd) else $error("conversion in power-down");

    property p_word_fmt;
        @(posedge i_clk_sys) disable iff (!rst_n_q)
        rd_valid_q && !soft_rst_q |=> o_data[DATA_W-2:0] == $past(rd_data[DATA_W-2:0])
            && o_data[DATA_W-1] == ($past(rd_data[DATA_W-1]) ^ $past(strap_q[STRAP_TWOS]));
    endproperty
    a_word_fmt: assert property (p_word_fmt) else $error("output word wrong");

    property p_ovr;
        @(posedge i_clk_sys) disable iff (!rst_n_q)
        rd_valid_q && !soft_rst_q |=> o_over_range_flag ==
            ($past(rd_data) == CODE_MAX || $past(rd_data) == CODE_MIN);
    endproperty
    a_ovr: assert property (p_ovr) else $error("over-range flag wrong");

    property p_oe_low;
        @(posedge i_clk_sys) disable iff (!rst_n_q)
        !sync1_q[1] |=> !o_data_oe;
    endproperty
    a_oe_low: assert property (p_oe_low) else $error("driving with enable low");

    property p_reset_pulse;
        @(posedge i_clk_sys) disable iff (!rst_n_q)
        rpin_s && rst_cnt_q == ($bits(rst_cnt_q))'(RST_MIN_CYC - 1) |=> ##1
            o_data == '0 && mode_q == MODE_RST;
    endproperty
    a_reset_pulse: assert property (p_reset_pulse) else $error("reset pulse not obeyed");

    property p_cap_fall;
        @(posedge i_clk_sys) disable iff (!rst_n_q)
        cap_en |-> $past(sclk_s) && !sclk_s;
    endproperty
    a_cap_fall: assert property (p_cap_fall) else $error("capture off falling edge");

    c_run: cover property (@(posedge i_clk_sys) disable iff (!rst_n_q) rd_valid_q);
    c_ser: cover property (@(posedge i_clk_sys) disable iff (!rst_n_q) ser_wr);
    c_pd: cover property (@(posedge i_clk_sys) disable iff (!rst_n_q)
        state_q == ST_RUN ##1 state_q == ST_CLK_PD);
endmodule : adc_ctrl

// ===== bench/ser_host.sv
`timescale 1ns/1ns
// Three-wire port host: sends one 16-bit mode word per request
module ser_host
(
    input wire logic i_clk_sys,
    input wire logic i_go,
    input wire logic [15:0] i_word,
    output logic o_ser_clk,
    output logic o_ser_sel_n,
    output logic o_ser_data,
    output logic o_busy
);
    // Link clock stands still between frames; data line shows no stale bit
    initial
    begin
        o_ser_clk = 1'h0;
        o_ser_sel_n = 1'h1;
        o_ser_data = 1'h0;
        o_busy = 1'h0;
        forever
        begin
            @(posedge i_clk_sys);
            if (i_go)
            begin
                o_busy <= 1'h1;
                o_ser_sel_n <= 1'h0;
                for (int b = 15; b >= 0; b--)
                begin
                    o_ser_data <= i_word[b]; // Msb first, 16 bits
                    // Four-cycle phases leave room for the sync flops
                    repeat (4) @(posedge i_clk_sys);
                    o_ser_clk <= 1'h1;
                    repeat (4) @(posedge i_clk_sys);
                    o_ser_clk <= 1'h0;
                end
                repeat (4) @(posedge i_clk_sys);
                o_ser_sel_n <= 1'h1;
                o_ser_data <= ~o_ser_data;
                o_busy <= 1'h0;
            end
        end
    end
endmodule : ser_host

// ===== bench/test_adc_output_and_mode_control.sv
`timescale 1ns/1ns
module test_adc_output_and_mode_control;
    import adc_ctrl_pkg::*;
    logic clk, arst_n, smp_clk, oe, rst_pin, psel, pen, pwr, go, smp_run, err;
    logic [1:0] strap;
    logic [DATA_W-1:0] code, raw;
    logic [7:0] paddr;
    logic [31:0] pwdata, rd;
    logic [15:0] word;
    logic [2:0] ph;
    int n, failures, n_compared;
    wire sclk, ssel_n, sdata, busy, pready, pslverr, d_oe, over_range_flag, ovr_oe, drc, c_oe, pd, byp, irq;
    wire [31:0] prdata;
    wire [DATA_W-1:0] dout;

    adc_ctrl adc_ctrl_i (.i_clk_sys(clk), .i_arst_n(arst_n), .i_sample_clk(smp_clk),
        .i_conv_code(code), .i_output_enable(oe), .i_reset_pin(rst_pin),
        .i_format_polarity_strap(strap), .i_ser_clk(sclk), .i_ser_sel_n(ssel_n),
        .i_ser_data(sdata), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .o_data(dout), .o_data_oe(d_oe), .o_over_range_flag(over_range_flag),
        .o_ovr_oe(ovr_oe), .o_data_ready_clock(drc), .o_clk_oe(c_oe),
        .o_power_down(pd), .o_dll_bypass(byp), .o_irq(irq));
    ser_host ser_host_i (.i_clk_sys(clk), .i_go(go), .i_word(word), .o_ser_clk(sclk),
        .o_ser_sel_n(ssel_n), .o_ser_data(sdata), .o_busy(busy));

    // Bench clock, 100 ns
    initial
    begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end

    // Sample clock of eight system cycles; code moves at the rise, stable at the fall
    always @(posedge clk)
        if (smp_run)
        begin
            ph <= ph + 3'h1;
            if (ph == 3'h3)
                smp_clk <= 1'h0;
            if (ph == 3'h7)
            begin
                smp_clk <= 1'h1;
                n <= n + 1;
                code <= fcode(n + 1);
            end
        end

    // Both full-scale limits and mid codes in turn
    function automatic logic [DATA_W-1:0] fcode(input int k);
        if (k % 3 == 0)
            return CODE_MIN;
        if (k % 3 == 1)
            return CODE_MAX;
        return DATA_W'(k * 5);
    endfunction : fcode

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'h1;
        do
            @(posedge clk);
        while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        pen <= 1'h0;
    endtask : apb

    task ser_write(input logic [15:0] w);
        @(posedge clk);
        go <= 1'h1;
        word <= w;
        @(posedge clk);
        go <= 1'h0;
        @(posedge clk);
        while (busy !== 1'h0)
            @(posedge clk);
        repeat (8) @(posedge clk);
    endtask : ser_write

    task t_reset;
        chk("data", 0, dout);
        chk("bypass", 0, byp);
        chk("pd", 1, pd);
        apb(1'h0, ADDR_MODE, 32'h0);
        chk("mode", 0, rd);
        apb(1'h0, 8'h20, 32'h0);
        chk("slverr", 1, err);
        chk("unmapped", 0, rd);
        $display("t_reset done");
    endtask : t_reset

    task t_samples(input logic [1:0] s);
        strap <= s;
        smp_run <= 1'h1;
        repeat (200) @(posedge clk);
        repeat (12)
        begin
            do
                @(posedge clk);
            while (ph !== 3'h7);
            raw = fcode(n - 17);
            chk("data", s[0] ? raw ^ 14'h2000 : raw, dout);
            chk("ovr", raw == CODE_MIN || raw == CODE_MAX, over_range_flag);
            chk("drc", !s[1], drc);
            chk("pd", 0, pd);
        end
        $display("t_samples done");
    endtask : t_samples

    task t_clock_pd;
        apb(1'h1, ADDR_IRQ_STAT, 32'hf);
        apb(1'h1, ADDR_IRQ_MASK, 32'h1 << IRQ_PD_ENTER);
        @(posedge clk);
        chk("irq", 0, irq);
        do
            @(posedge clk);
        while (ph !== 3'h5);
        smp_run <= 1'h0;
        repeat (30) @(posedge clk);
        chk("pd", 1, pd);
        chk("data_oe", 1, d_oe);
        chk("drc", strap[1], drc);
        chk("irq", 1, irq);
        apb(1'h1, ADDR_IRQ_STAT, 32'h1 << IRQ_PD_ENTER);
        @(posedge clk);
        chk("irq", 0, irq);
        $display("t_clock_pd done");
    endtask : t_clock_pd

    task t_serial;
        ser_write(16'h1 << DLL_OFF_BIT_DEF);
        chk("bypass", 1, byp);
        apb(1'h0, ADDR_MODE, 32'h0);
        chk("mode", 32'h1 << DLL_OFF_BIT_DEF, rd);
        apb(1'h0, ADDR_IRQ_STAT, 32'h0);
        chk("irq_ser", 1, rd[IRQ_SER_WR]);
        ser_write((16'h1 << DLL_OFF_BIT_DEF) | (16'h1 << PD_BIT_DEF));
        chk("pd", 1, pd);
        chk("outs_oe", 0, {d_oe, ovr_oe, c_oe});
        ser_write(16'h1 << DLL_OFF_BIT_DEF);
        chk("outs_oe", 3'h7, {d_oe, ovr_oe, c_oe});
        oe <= 1'h0;
        repeat (5) @(posedge clk);
        chk("outs_oe", 0, {d_oe, ovr_oe, c_oe});
        oe <= 1'h1;
        repeat (5) @(posedge clk);
        chk("data_oe", 1, d_oe);
        $display("t_serial done");
    endtask : t_serial

    task t_reset_pin;
        rst_pin <= 1'h1;
        repeat (10) @(posedge clk);
        rst_pin <= 1'h0;
        repeat (5) @(posedge clk);
        chk("bypass", 1, byp);
        rst_pin <= 1'h1;
        repeat (RST_MIN_CYC + 5) @(posedge clk);
        rst_pin <= 1'h0;
        repeat (5) @(posedge clk);
        chk("bypass", 0, byp);
        chk("data", 0, dout);
        apb(1'h0, ADDR_MODE, 32'h0);
        chk("mode", 0, rd);
        $display("t_reset_pin done");
    endtask : t_reset_pin

    task complete_run;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run

    // Main sequence
    initial
    begin
        {arst_n, oe, rst_pin, psel, pen, pwr, go, smp_run} = 8'h40;
        {strap, code, paddr, pwdata, word, ph, n} = '0;
        smp_clk = 1'h1;
        repeat (4) @(posedge clk);
        arst_n <= 1'h1;
        repeat (4) @(posedge clk);
        t_reset();
        for (int s = 0; s < 4; s++)
            t_samples(2'(s));
        t_clock_pd();
        t_serial();
        t_reset_pin();
        complete_run();
    end

    // Watchdog well past the expected few thousand cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        failures++;
        complete_run();
    end
endmodule : test_adc_output_and_mode_control
